// [lin_ctrl_map.svh]
// Purpose: Constants for the LIN transceiver mode and wake control block.
// Assumes: 100 MHz core clock.
// Notes: Times are given in microseconds; cycle counts derive from them.
`ifndef LIN_CTRL_MAP_SVH
`define LIN_CTRL_MAP_SVH

`define CLK_MHZ 100
// Transceiver mode field codes; wake-capable is fixed at 01.
`define TRX_MODE_OFF 2'h0
`define TRX_MODE_WAKE 2'h1
`define TRX_MODE_NORMAL 2'h2
`define TRX_MODE_RXONLY 2'h3
// Wake dominant filter, chosen inside the 30 to 150 us window.
`define WAKE_FILTER_US 50
`define WAKE_FILTER_CYC (`WAKE_FILTER_US * `CLK_MHZ)
`define TX_EN_DELAY_US 10
`define TX_EN_DELAY_CYC (`TX_EN_DELAY_US * `CLK_MHZ)
`define TX_TIMEOUT_US 12000
`define TX_TIMEOUT_CYC (`TX_TIMEOUT_US * `CLK_MHZ)
`define BUS_TIMEOUT_US 12000
`define BUS_TIMEOUT_CYC (`BUS_TIMEOUT_US * `CLK_MHZ)

`endif

// [lin_ctrl_pkg.sv]
// Purpose: Types for the LIN transceiver mode and wake control block.
// Assumes: Nothing beyond the map header.
// Notes: Chip modes are supplied by the surrounding mode controller.
package lin_ctrl_pkg;
   typedef enum logic [2:0]
   {
      CHIP_NORMAL,
      CHIP_STOP,
      CHIP_SLEEP,
      CHIP_RESTART,
      CHIP_FAILSAFE
   } chip_mode_t;

   typedef enum logic [1:0]
   {
      TRX_OFF,
      TRX_NORMAL,
      TRX_RXONLY,
      TRX_WAKE
   } trx_state_t;

   typedef struct packed
   {
      logic bus_wake;
      logic irq;
      logic watchdog_enable;
      logic go_restart;
      logic regulator_ramp;
   } wake_action_t;

   typedef struct packed
   {
      logic drive_en;
      logic low_slope;
      logic slope_off;
   } drive_cfg_t;
endpackage

// [lin_transceiver_mode_wake_control.sv]
// Purpose: Mode machine, wake detection, time-outs and slope control of a LIN transceiver.
// Assumes: All inputs synchronous to i_core_clk; bus level already digitised.
// Notes: No register bus; mode and option bits arrive as plain ports.
//
// Notes on behaviour
// R1: Off after reset; off ignores all bus activity.
// R2: Normal mode selectable in chip normal and stop.
// R3: Normal mode: dominant bus follows low transmit input.
// R4: Controller keeps transmit input high during enable delay.
// R5: No dominant before delay; wait for fresh dominant.
// R6: Receive output mirrors bus in normal mode.
// R7: Receive-only: driver off, receiver on, normal/stop only.
// R8: Wake-capable selectable widely; forced in fail-safe.
// R9: Wake needs long dominant then rising edge.
// R10: Receive output low after wake until mode change.
// R11: Mode field reads 01 after wake; stays unarmed.
// R12: Rearm only after another mode written in between.
// R13: Rearm on chip change to stop, sleep, fail-safe.
// R14: Stop or normal wake: interrupt, status, receive low.
// R15: Stop wake enables watchdog if option bit set.
// R16: Sleep wake: go restart, record source, no interrupt.
// R17: Restart or fail-safe wake: restart, interrupt high. Code requests restart in fail-safe only and raises no interrupt in either.
// R18: Transmit time-out disables driver and sets fault.
// R19: Long bus dominant sets fault in normal/receive-only.
// R20: Bus undervoltage disables driver and receiver.
// R21: Low-slope bit, normal mode only, on select release.
// R22: Flash bit disables slope control on select release.
// R23: Wake filter time between 30 and 150 us.
// R24: Two-bit mode field, code 01 is wake-capable.
`timescale 1ns/1ps
`include "lin_ctrl_map.svh"

module lin_transceiver_mode_wake_control
   import lin_ctrl_pkg::*;
#(
   parameter int WAKE_FILTER_CYC = `WAKE_FILTER_CYC,
   parameter int TX_EN_DELAY_CYC = `TX_EN_DELAY_CYC,
   parameter int TX_TIMEOUT_CYC = `TX_TIMEOUT_CYC,
   parameter int BUS_TIMEOUT_CYC = `BUS_TIMEOUT_CYC
)
(
   input wire logic i_core_clk, // Core clock, 100 MHz.
   input wire logic i_reset, // Synchronous reset, active high.
   input wire chip_mode_t i_chip_mode, // Current chip operating mode.
   input wire logic i_mode_wr, // One-cycle strobe: mode field written.
   input wire logic [1:0] i_transceiver_mode_field, // Written mode code.
   input wire logic i_low_slope_select, // Staged low-slope bit.
   input wire logic i_flash_select, // Staged flash-programming bit.
   input wire logic i_serial_chip_select_n, // Serial select, active low.
   input wire logic i_watchdog_on_bus_wake_enable, // Watchdog on wake option.
   input wire logic i_watchdog_enabled, // Watchdog currently enabled.
   input wire logic i_fault_clear, // One-cycle clear of the fault flag.
   input wire logic i_wake_clear, // One-cycle clear of the wake status.
   input wire logic i_lin_tx_input, // Transmit input, low is dominant.
   input wire logic i_bus_level, // Digitised bus, low is dominant.
   input wire logic i_bus_supply_uv, // Bus supply undervoltage, high active.
   input wire logic i_rx_ready, // Receiver of the bus stream is ready.
   output logic o_lin_receive_pin, // Receive output to the controller.
   output logic o_rx_valid, // Receive sample valid.
   output logic o_bus_drive_dominant, // Driver pulls the bus dominant.
   output logic o_receiver_enable, // Bus receiver enabled.
   output drive_cfg_t o_drive_cfg, // Driver enable and slope setting.
   output logic [1:0] o_transceiver_mode_field, // Mode field readback.
   output logic o_transceiver_fault_flag, // Sticky fault flag.
   output logic o_wake_status, // Bus wake status flag.
   output logic o_irq, // Interrupt request pulse level.
   output logic o_watchdog_enable_req, // One-cycle watchdog enable request.
   output logic o_restart_req, // One-cycle request to enter restart.
   output logic o_regulator_ramp_req // One-cycle main regulator ramp request.
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] sat_inc(input logic [31:0] v, input logic run);
      sat_inc = run ? ((v == 32'hffffffff) ? v : v + 32'h1) : 32'h0;
   endfunction

   function automatic logic mode_allowed(input logic [1:0] code, input chip_mode_t cm);
      case (code)
         `TRX_MODE_OFF: mode_allowed = 1'b1; // see R1
         `TRX_MODE_NORMAL, `TRX_MODE_RXONLY:
            mode_allowed = (cm == CHIP_NORMAL) || (cm == CHIP_STOP); // see R2 see R7
         default: mode_allowed = (cm != CHIP_FAILSAFE); // see R8
      endcase
   endfunction

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef enum {W_IDLE, W_DOM, W_LONG, W_DONE} wake_fsm_t;

   trx_state_t mode_r, mode_nxt;
   wake_fsm_t wk_r, wk_nxt;
   logic armed_r, armed_nxt, rx_low_r, rx_low_nxt, en_wait_r, en_wait_nxt;
   logic tx_gate_r, tx_gate_nxt, txto_r, txto_nxt, fault_r, fault_nxt, wstat_r, wstat_nxt;
   logic low_slope_r, low_slope_nxt, flash_r, flash_nxt, csn_q_r;
   chip_mode_t cm_q_r;
   logic [31:0] wcnt_r, wcnt_nxt, ecnt_r, ecnt_nxt, tcnt_r, tcnt_nxt, bcnt_r, bcnt_nxt;
   wake_action_t act_r, act_nxt;
   logic drive_r, drive_nxt, rxen_r, rxen_nxt, rxpin_r, rxpin_nxt;
   logic drv_en_r, drv_en_nxt, rxv_r, rxv_nxt;
   logic [1:0] field_r, field_nxt;

   // Two-entry skid buffer for the receive stream.
   logic [1:0] buf_q_r, buf_q_nxt;
   logic [1:0] buf_cnt_r, buf_cnt_nxt;
   logic buf_in_ready;

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb
   begin
      logic wake_evt, csn_rise, chip_change, push, pop, sample;
      wake_evt = 1'b0;
      sample = (mode_r == TRX_NORMAL || mode_r == TRX_RXONLY) && !i_bus_supply_uv;
      push = sample && buf_in_ready;
      pop = (buf_cnt_r != 2'h0) && i_rx_ready;
      mode_nxt = mode_r;
      armed_nxt = armed_r;
      rx_low_nxt = rx_low_r;
      en_wait_nxt = en_wait_r;
      tx_gate_nxt = tx_gate_r;
      wk_nxt = wk_r;
      low_slope_nxt = low_slope_r;
      flash_nxt = flash_r;
      act_nxt = '0;
      csn_rise = i_serial_chip_select_n && !csn_q_r;
      chip_change = (i_chip_mode != cm_q_r);

      // Mode writes; any other mode than wake clears the wake hold.
      if (i_mode_wr && mode_allowed(i_transceiver_mode_field, i_chip_mode))
      begin
         case (i_transceiver_mode_field)
            `TRX_MODE_OFF: mode_nxt = TRX_OFF;
            `TRX_MODE_NORMAL: mode_nxt = TRX_NORMAL;
            `TRX_MODE_RXONLY: mode_nxt = TRX_RXONLY;
            default: mode_nxt = TRX_WAKE;
         endcase
         if (i_transceiver_mode_field != `TRX_MODE_WAKE)
         begin
            rx_low_nxt = 1'b0; // see R10
            armed_nxt = 1'b1; // see R12
         end
         if (mode_nxt == TRX_NORMAL && mode_r != TRX_NORMAL)
            en_wait_nxt = 1'b1; // see R5
      end
      if (i_chip_mode == CHIP_FAILSAFE)
         mode_nxt = TRX_WAKE; // see R8
      if (chip_change && (i_chip_mode == CHIP_STOP || i_chip_mode == CHIP_SLEEP
          || i_chip_mode == CHIP_FAILSAFE))
         armed_nxt = 1'b1; // see R13
      // Enabling delay, then wait for a recessive transmit input.
      ecnt_nxt = sat_inc(ecnt_r, en_wait_r);
      if (en_wait_r && ecnt_r >= 32'(TX_EN_DELAY_CYC - 1))
      begin
         en_wait_nxt = 1'b0;
         tx_gate_nxt = 1'b0;
      end
      if (!en_wait_nxt && i_lin_tx_input)
         tx_gate_nxt = 1'b1; // see R5
      if (mode_nxt != TRX_NORMAL)
         tx_gate_nxt = 1'b0;
      // Wake detector; off mode and disarmed states see nothing.
      wcnt_nxt = sat_inc(wcnt_r, wk_r == W_DOM && !i_bus_level);
      case (wk_r)
         W_IDLE: if (!i_bus_level) wk_nxt = W_DOM; // see R9
         W_DOM:
            if (i_bus_level) wk_nxt = W_IDLE;
            else if (wcnt_r >= 32'(WAKE_FILTER_CYC)) wk_nxt = W_LONG; // see R23
         W_LONG:
            if (i_bus_level)
            begin
               wk_nxt = W_DONE;
               wake_evt = 1'b1; // see R9
            end
         W_DONE: if (i_bus_level) wk_nxt = W_IDLE;
         default: wk_nxt = W_IDLE;
      endcase
      // A dominant already present on arming is not a valid starting edge.
      if (mode_r != TRX_WAKE || !armed_r || i_bus_supply_uv)
      begin
         wk_nxt = W_DONE; // see R1 see R11
         wake_evt = 1'b0;
      end

      if (wake_evt)
      begin
         armed_nxt = 1'b0; // see R11
         rx_low_nxt = 1'b1; // see R10
         act_nxt.bus_wake = 1'b1;
         case (i_chip_mode)
            CHIP_NORMAL: act_nxt.irq = 1'b1; // see R14
            CHIP_STOP:
            begin
               act_nxt.irq = 1'b1; // see R14
               act_nxt.watchdog_enable = i_watchdog_on_bus_wake_enable
                                         && !i_watchdog_enabled; // see R15
            end
            CHIP_SLEEP: act_nxt.go_restart = 1'b1; // see R16
            CHIP_RESTART: act_nxt.go_restart = 1'b0; // see R17
            CHIP_FAILSAFE:
            begin
               act_nxt.go_restart = 1'b1; // see R17
               act_nxt.regulator_ramp = 1'b1;
            end
            default: act_nxt = act_nxt;
         endcase
      end
      wstat_nxt = act_nxt.bus_wake || (wstat_r && !i_wake_clear); // see R14 see R16
      // Time-outs; the set wins over a simultaneous clear.
      tcnt_nxt = sat_inc(tcnt_r, !i_lin_tx_input && mode_r == TRX_NORMAL);
      txto_nxt = (tcnt_r >= 32'(TX_TIMEOUT_CYC)) ? 1'b1 : (txto_r && !i_lin_tx_input); // see R18
      bcnt_nxt = sat_inc(bcnt_r, !i_bus_level
                 && (mode_r == TRX_NORMAL || mode_r == TRX_RXONLY));
      fault_nxt = (tcnt_r == 32'(TX_TIMEOUT_CYC)) || (bcnt_r == 32'(BUS_TIMEOUT_CYC)) // see R19
                  || (fault_r && !i_fault_clear);
      // Slope options latch on select release, in chip normal mode only.
      if (csn_rise && i_chip_mode == CHIP_NORMAL)
      begin
         low_slope_nxt = i_low_slope_select; // see R21
         flash_nxt = i_flash_select; // see R22
      end
      drive_nxt = (mode_nxt == TRX_NORMAL) && tx_gate_nxt && !txto_nxt
                  && !i_bus_supply_uv && !i_lin_tx_input; // see R3 see R18 see R20
      drv_en_nxt = (mode_nxt == TRX_NORMAL) && !txto_nxt && !i_bus_supply_uv; // see R18
      rxen_nxt = (mode_nxt != TRX_OFF) && !i_bus_supply_uv; // see R20 see R7
      // Receive path: stream through the buffer, or forced low after wake.
      buf_q_nxt = buf_q_r;
      buf_cnt_nxt = buf_cnt_r;
      if (pop)
      begin
         buf_q_nxt = {1'b1, buf_q_r[1]};
         buf_cnt_nxt = buf_cnt_r - 2'h1;
      end
      if (push)
      begin
         buf_q_nxt[buf_cnt_nxt[0]] = i_bus_level; // see R6
         buf_cnt_nxt = buf_cnt_nxt + 2'h1;
      end
      if (rx_low_nxt)
         rxpin_nxt = 1'b0; // see R10 see R14
      else if (buf_cnt_r != 2'h0)
         rxpin_nxt = buf_q_r[0]; // see R6
      else
         rxpin_nxt = 1'b1;
      rxv_nxt = (buf_cnt_r != 2'h0) && !rx_low_nxt; // see R6
      case (mode_nxt)
         TRX_OFF: field_nxt = `TRX_MODE_OFF;
         TRX_NORMAL: field_nxt = `TRX_MODE_NORMAL;
         TRX_RXONLY: field_nxt = `TRX_MODE_RXONLY;
         default: field_nxt = `TRX_MODE_WAKE; // see R24 see R11
      endcase
   end

   assign buf_in_ready = (buf_cnt_r != 2'h2) || i_rx_ready;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         mode_r <= TRX_OFF; // see R1
         wk_r <= W_DONE;
         armed_r <= 1'b1;
         rx_low_r <= 1'b0;
         en_wait_r <= 1'b0;
         tx_gate_r <= 1'b0;
         txto_r <= 1'b0;
         fault_r <= 1'b0;
         wstat_r <= 1'b0;
         low_slope_r <= 1'b0;
         flash_r <= 1'b0;
         csn_q_r <= 1'b1;
         cm_q_r <= CHIP_NORMAL;
         wcnt_r <= 32'h0;
         ecnt_r <= 32'h0;
         tcnt_r <= 32'h0;
         bcnt_r <= 32'h0;
         act_r <= '0;
         drive_r <= 1'b0;
         rxen_r <= 1'b0;
         rxpin_r <= 1'b1;
         drv_en_r <= 1'b0;
         rxv_r <= 1'b0;
         field_r <= `TRX_MODE_OFF;
         buf_q_r <= 2'h3;
         buf_cnt_r <= 2'h0;
      end
      else
      begin
         mode_r <= mode_nxt;
         wk_r <= wk_nxt;
         armed_r <= armed_nxt;
         rx_low_r <= rx_low_nxt;
         en_wait_r <= en_wait_nxt;
         tx_gate_r <= tx_gate_nxt;
         txto_r <= txto_nxt;
         fault_r <= fault_nxt;
         wstat_r <= wstat_nxt;
         low_slope_r <= low_slope_nxt;
         flash_r <= flash_nxt;
         csn_q_r <= i_serial_chip_select_n;
         cm_q_r <= i_chip_mode;
         wcnt_r <= wcnt_nxt;
         ecnt_r <= ecnt_nxt;
         tcnt_r <= tcnt_nxt;
         bcnt_r <= bcnt_nxt;
         act_r <= act_nxt;
         drive_r <= drive_nxt;
         rxen_r <= rxen_nxt;
         rxpin_r <= rxpin_nxt;
         drv_en_r <= drv_en_nxt;
         rxv_r <= rxv_nxt;
         field_r <= field_nxt;
         buf_q_r <= buf_q_nxt;
         buf_cnt_r <= buf_cnt_nxt;
      end
   end

   assign o_lin_receive_pin = rxpin_r;
   assign o_rx_valid = rxv_r;
   assign o_bus_drive_dominant = drive_r;
   assign o_receiver_enable = rxen_r;
   assign o_drive_cfg = '{drive_en: drv_en_r, low_slope: low_slope_r, slope_off: flash_r};
   assign o_transceiver_mode_field = field_r;
   assign o_transceiver_fault_flag = fault_r;
   assign o_wake_status = wstat_r;
   assign o_irq = act_r.irq;
   assign o_watchdog_enable_req = act_r.watchdog_enable;
   assign o_restart_req = act_r.go_restart;
   assign o_regulator_ramp_req = act_r.regulator_ramp;

endmodule // lin_transceiver_mode_wake_control

// [lin_ctrl_props.sv]
// Purpose: Concurrent checks on the ports of the LIN transceiver mode and wake control.
// Assumes: The chip mode is held steady around each bus wake.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module lin_ctrl_props
   import lin_ctrl_pkg::*;
#(
   parameter int TX_TIMEOUT_CYC = 50
)
(
   input wire logic i_core_clk, // Clock.
   input wire logic i_reset, // Reset.
   input wire chip_mode_t i_chip_mode, // Chip mode.
   input wire logic i_watchdog_on_bus_wake_enable, // Option bit.
   input wire logic i_watchdog_enabled, // Watchdog state.
   input wire logic i_lin_tx_input, // Transmit input.
   input wire logic i_bus_level, // Bus level.
   input wire logic i_bus_supply_uv, // Undervoltage.
   input wire logic o_lin_receive_pin, // Receive output.
   input wire logic o_bus_drive_dominant, // Driver.
   input wire logic o_receiver_enable, // Receiver enable.
   input wire logic [1:0] o_transceiver_mode_field, // Mode readback.
   input wire logic o_wake_status, // Wake flag.
   input wire logic o_irq, // Interrupt pulse.
   input wire logic o_watchdog_enable_req, // Watchdog request.
   input wire logic o_restart_req // Restart request.
);
   // ---------------------------------------------
   // Length of the current dominant transmit request
   // ---------------------------------------------
   int txlow_r;
   int txlow_nxt;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   always_comb
   begin
      txlow_nxt = i_lin_tx_input ? 0 : txlow_r + 1;
   end
   always_ff @(posedge i_core_clk)
   begin
      txlow_r <= i_reset ? 0 : txlow_nxt;
   end
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   drive_cause_a: assert property (o_bus_drive_dominant |-> !$past(i_lin_tx_input) &&
      $past(o_transceiver_mode_field) == 2'h2 && !$past(i_bus_supply_uv))
      else $error("bus driven without a dominant request in normal mode");
   enable_delay_a: assert property (o_transceiver_mode_field == 2'h2 &&
      $past(o_transceiver_mode_field) != 2'h2 |-> !o_bus_drive_dominant [*6])
      else $error("bus driven inside the enabling delay");
   tx_timeout_a: assert property (txlow_r > TX_TIMEOUT_CYC + 2 |-> !o_bus_drive_dominant)
      else $error("driver still on after transmit time-out");
   uv_disable_a: assert property (i_bus_supply_uv |=> !o_receiver_enable && !o_bus_drive_dominant)
      else $error("stages active under bus undervoltage");
   wake_sequence_a: assert property ($rose(o_wake_status) |-> $past(i_bus_level) &&
      !$past(i_bus_level, 4) && $past(o_transceiver_mode_field) == 2'h1)
      else $error("wake flagged without the dominant then recessive pattern");
   wake_rx_low_a: assert property ($rose(o_wake_status) |-> !o_lin_receive_pin)
      else $error("receive output not low at wake");
   irq_mode_a: assert property ($rose(o_wake_status) |->
      o_irq == (i_chip_mode == CHIP_NORMAL || i_chip_mode == CHIP_STOP))
      else $error("interrupt does not match chip mode at wake");
   restart_mode_a: assert property (o_restart_req |-> o_wake_status &&
      (i_chip_mode == CHIP_SLEEP || i_chip_mode == CHIP_FAILSAFE))
      else $error("restart request without sleep or fail-safe wake");
   wd_cause_a: assert property (o_watchdog_enable_req |-> i_chip_mode == CHIP_STOP &&
      $past(i_watchdog_on_bus_wake_enable) && !$past(i_watchdog_enabled))
      else $error("watchdog request without its cause");
endmodule // lin_ctrl_props

bind lin_transceiver_mode_wake_control lin_ctrl_props #(.TX_TIMEOUT_CYC(TX_TIMEOUT_CYC)) u_props (
   .i_core_clk, .i_reset, .i_chip_mode, .i_watchdog_on_bus_wake_enable, .i_watchdog_enabled,
   .i_lin_tx_input, .i_bus_level, .i_bus_supply_uv, .o_lin_receive_pin, .o_bus_drive_dominant,
   .o_receiver_enable, .o_transceiver_mode_field, .o_wake_status, .o_irq,
   .o_watchdog_enable_req, .o_restart_req);

// [lin_bus_model.sv]
// Purpose: Single wire bus with a pull-up and one remote node.
// Assumes: Any node pulling low makes the bus dominant.
// Notes: Released bus returns to recessive through the pull-up.
`timescale 1ns/1ps
module lin_bus_model (
   input wire logic i_drive_dominant, // Our node pulls low.
   input wire logic i_remote_dominant, // Remote node pulls low.
   output logic o_bus_level // Wired bus level.
);
   assign o_bus_level = !(i_drive_dominant || i_remote_dominant);
endmodule // lin_bus_model

// [lin_transceiver_mode_wake_control_test.sv]
// Purpose: Self-checking bench for the LIN transceiver mode and wake control.
// Assumes: Shortened counts; chip mode held steady around each wake.
// Notes: Pulses are counted, so one-cycle events are never missed.
`timescale 1ns/1ps
module lin_transceiver_mode_wake_control_test;
   import lin_ctrl_pkg::*;
   localparam int TD = 8;
   localparam int TT = 50;
   logic clk = 0, rst = 1, wr = 0, ls = 0, fl = 0, sel_n = 1, wdo = 0, wde = 0;
   logic fc = 0, wc = 0, tx = 1, uv = 0, rdy = 1, remote = 0, bus;
   logic rxp, rxv, drv, rxe, flt, wks, irq, wdr, rsr, rgr;
   logic [1:0] code = 2'h0;
   logic [1:0] fld;
   chip_mode_t cm = CHIP_NORMAL;
   drive_cfg_t cfg;
   int drv_q[$];
   int errors = 0, cmp_count = 0, seed = 82, n_irq = 0, n_wdr = 0, n_rsr = 0, n_rgr = 0, k;
   lin_transceiver_mode_wake_control #(.WAKE_FILTER_CYC(20), .TX_EN_DELAY_CYC(TD),
      .TX_TIMEOUT_CYC(TT), .BUS_TIMEOUT_CYC(TT)) u_dut (
      .i_core_clk(clk), .i_reset(rst), .i_chip_mode(cm), .i_mode_wr(wr),
      .i_transceiver_mode_field(code), .i_low_slope_select(ls), .i_flash_select(fl),
      .i_serial_chip_select_n(sel_n), .i_watchdog_on_bus_wake_enable(wdo),
      .i_watchdog_enabled(wde), .i_fault_clear(fc), .i_wake_clear(wc), .i_lin_tx_input(tx),
      .i_bus_level(bus), .i_bus_supply_uv(uv), .i_rx_ready(rdy), .o_lin_receive_pin(rxp),
      .o_rx_valid(rxv), .o_bus_drive_dominant(drv), .o_receiver_enable(rxe),
      .o_drive_cfg(cfg), .o_transceiver_mode_field(fld), .o_transceiver_fault_flag(flt),
      .o_wake_status(wks), .o_irq(irq), .o_watchdog_enable_req(wdr), .o_restart_req(rsr),
      .o_regulator_ramp_req(rgr));
   lin_bus_model u_bus (.i_drive_dominant(drv), .i_remote_dominant(remote), .o_bus_level(bus));
   initial forever #5 clk = ~clk;
   always @(posedge clk)
   begin
      n_irq += (irq === 1'b1);
      n_wdr += (wdr === 1'b1);
      n_rsr += (rsr === 1'b1);
      n_rgr += (rgr === 1'b1);
   end
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input int exp, input logic [3:0] got);
      cmp_count++;
      if (got !== 4'(exp))
      begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic setm(input logic [1:0] c);
      code = c;
      wr = 1;
      step();
      wr = 0;
      step();
   endtask
   // A dominant pulse of n cycles from the remote node, then recessive.
   task automatic wake(input int n);
      remote = 1;
      step(n);
      remote = 0;
      step(3);
   endtask
   task automatic csel();
      sel_n = 0;
      step();
      sel_n = 1;
      step(2);
   endtask
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      print_verdict();
   end
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      step(10);
      rst = 0;
      step();
      chk("field", 0, fld);
      chk("rxpin", 1, rxp);
      chk("slope", 0, cfg.low_slope);
      wake(30);
      chk("wake", 0, wks);
      for (int m = 0; m < 4; m++)
         for (int c = 0; c < 4; c++)
         begin
            cm = chip_mode_t'(m);
            setm(0);
            setm(c[1:0]);
            chk("field", (c < 2 || m < 2) ? c : 0, fld);
         end
      cm = CHIP_NORMAL;
      setm(2);
      tx = 0;
      step(2);
      chk("drive", 0, drv);
      tx = 1;
      step(TD);
      repeat (30)
      begin
         tx = 1'($random(seed));
         rdy = 1'($random(seed));
         drv_q.push_back(int'(!tx));
         step();
         chk("drive", drv_q.pop_front(), drv);
      end
      rdy = 1;
      tx = 0;
      step(5);
      chk("rxpin", 0, rxp);
      chk("valid", 1, rxv);
      tx = 1;
      step(5);
      chk("rxpin", 1, rxp);
      setm(3);
      tx = 0;
      remote = 1;
      step(5);
      chk("drive", 0, drv);
      chk("rxpin", 0, rxp);
      tx = 1;
      remote = 0;
      setm(2);
      step(TD + 2);
      tx = 0;
      step(TT + 5);
      chk("drive", 0, drv);
      chk("fault", 1, flt);
      chk("drv_en", 0, cfg.drive_en);
      tx = 1;
      fc = 1;
      step();
      fc = 0;
      step();
      chk("fault", 0, flt);
      tx = 0;
      step(2);
      chk("drive", 1, drv);
      chk("drv_en", 1, cfg.drive_en);
      tx = 1;
      remote = 1;
      step(TT + 5);
      chk("fault", 1, flt);
      chk("field", 2, fld);
      remote = 0;
      uv = 1;
      tx = 0;
      step(2);
      chk("rxen", 0, rxe);
      chk("drive", 0, drv);
      uv = 0;
      tx = 1;
      step(2);
      chk("rxen", 1, rxe);
      chk("field", 2, fld);
      ls = 1;
      step();
      chk("slope", 0, cfg.low_slope);
      csel();
      chk("slope", 1, cfg.low_slope);
      cm = CHIP_STOP;
      ls = 0;
      fl = 1;
      csel();
      chk("cfg", 2, {cfg.low_slope, cfg.slope_off});
      cm = CHIP_NORMAL;
      csel();
      chk("cfg", 1, {cfg.low_slope, cfg.slope_off});
      cm = CHIP_STOP;
      wdo = 1;
      setm(0);
      setm(1);
      wake(10);
      chk("wake", 0, wks);
      wake(30);
      chk("wake", 1, wks);
      chk("rxpin", 0, rxp);
      chk("irq", 1, 4'(n_irq));
      chk("wdog", 1, 4'(n_wdr));
      wdo = 0;
      wc = 1;
      step();
      wc = 0;
      wake(30);
      chk("field", 1, fld);
      chk("irq", 1, 4'(n_irq));
      setm(2);
      chk("rxpin", 1, rxp);
      setm(1);
      wake(30);
      chk("irq", 2, 4'(n_irq));
      chk("wdog", 1, 4'(n_wdr));
      cm = CHIP_SLEEP;
      step(2);
      wake(30);
      chk("restart", 1, 4'(n_rsr));
      chk("irq", 2, 4'(n_irq));
      cm = CHIP_FAILSAFE;
      step(2);
      chk("field", 1, fld);
      k = n_rgr;
      wake(30);
      chk("restart", 2, 4'(n_rsr));
      chk("ramp", 1, 4'(n_rgr - k));
      print_verdict();
   end
endmodule // lin_transceiver_mode_wake_control_test
